// *** logic/rtc_pins_pkg.sv ***
// Shared constants and types for the real-time clock output pin logic
package rtc_pins_pkg;
	// Core clock rate
	localparam int CLK_KHZ = 40000;

	// Times in milliseconds, as specified
	localparam int DEBOUNCE_MS       = 250;
	localparam int RST_HOLD_MS       = 250;
	localparam int REC_HOLD_MS       = 125;
	localparam int OSF_DELAY_MS      = 100;
	localparam int SERIAL_TIMEOUT_MS = 25;

	// Same times in core clock cycles
	localparam int DEBOUNCE_CYCLES       = DEBOUNCE_MS * CLK_KHZ;
	localparam int RST_HOLD_CYCLES       = RST_HOLD_MS * CLK_KHZ;
	localparam int REC_HOLD_CYCLES       = REC_HOLD_MS * CLK_KHZ;
	localparam int OSF_DELAY_CYCLES      = OSF_DELAY_MS * CLK_KHZ;
	localparam int SERIAL_TIMEOUT_CYCLES = SERIAL_TIMEOUT_MS * CLK_KHZ;

	// Control register
	localparam logic [7:0] CTL_ADDR    = 8'h0e;
	localparam logic [7:0] CTL_RESET   = 8'h04;
	localparam int         CTL_OSC_DIS = 7;
	localparam int         CTL_RATE_HI = 4;
	localparam int         CTL_RATE_LO = 3;
	localparam int         CTL_SELECT  = 2;
	localparam int         CTL_A2_EN   = 1;
	localparam int         CTL_A1_EN   = 0;

	// Oscillator stop flag value after reset
	localparam logic OSF_RESET = 1'h1;

	// Square-wave half periods in oscillator rising edges, per rate select
	localparam int          WAVE_W       = 15;
	localparam logic [14:0] HALF_RATE_0  = 15'h4000;
	localparam logic [14:0] HALF_RATE_1  = 15'h0010;
	localparam logic [14:0] HALF_RATE_2  = 15'h0004;
	localparam logic [14:0] HALF_RATE_3  = 15'h0002;

	// Conditioned pin inputs
	localparam int         SENSE_N      = 4;
	localparam int         SENSE_SUPPLY = 0;
	localparam int         SENSE_BATT   = 1;
	localparam int         SENSE_RST    = 2;
	localparam int         SENSE_OSC    = 3;
	localparam logic [3:0] SENSE_RESET  = 4'h5;

	typedef enum logic [2:0] {
		POWER_FAIL,
		RECOVER,
		IDLE,
		DEBOUNCE,
		WAIT_RISE,
		RST_HOLD
	} rst_state_t;
endpackage : rtc_pins_pkg

// *** logic/pin_sense_if.sv ***
// Conditioned pin levels passed from the input conditioner to the pin logic
`timescale 1ns/1ps
interface pin_sense_if;
	logic [rtc_pins_pkg::SENSE_N-1:0] level;

	modport conditioner (output level);
	modport consumer    (input  level);
endinterface : pin_sense_if

// *** logic/pin_conditioner.sv ***
// Three-stage synchroniser with agreement filter for the external pin inputs
`timescale 1ns/1ps
module pin_conditioner (
	input  wire logic                             i_clk,
	input  wire logic                             i_rst_b,
	input  wire logic [rtc_pins_pkg::SENSE_N-1:0] i_raw,
	pin_sense_if.conditioner                      sense
);
	logic [rtc_pins_pkg::SENSE_N-1:0] stage1;
	logic [rtc_pins_pkg::SENSE_N-1:0] stage2;
	logic [rtc_pins_pkg::SENSE_N-1:0] stage3;
	logic [rtc_pins_pkg::SENSE_N-1:0] filtered;
	logic [rtc_pins_pkg::SENSE_N-1:0] next_filtered;

	////////////////////////////////////////////////////////////////
	// A bit sets only once the second and third stages agree high, and clears as soon as they disagree
	always_comb begin
		next_filtered = (filtered & ~(stage2 ^ stage3)) | (stage2 & ~(stage2 ^ stage3));
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			stage1   <= rtc_pins_pkg::SENSE_RESET;
			stage2   <= rtc_pins_pkg::SENSE_RESET;
			stage3   <= rtc_pins_pkg::SENSE_RESET;
			filtered <= rtc_pins_pkg::SENSE_RESET;
		end else begin
			stage1   <= i_raw;
			stage2   <= stage1;
			stage3   <= stage2;
			filtered <= next_filtered;
		end
	end

	assign sense.level = filtered;
endmodule : pin_conditioner

// *** logic/rtc_output_pin_control.sv ***
// Reset, interrupt/square-wave and clock-out pin logic of the real-time clock
`timescale 1ns/1ps
module rtc_output_pin_control #(
	parameter int DEBOUNCE_CYCLES       = rtc_pins_pkg::DEBOUNCE_CYCLES,
	parameter int RST_HOLD_CYCLES       = rtc_pins_pkg::RST_HOLD_CYCLES,
	parameter int REC_HOLD_CYCLES       = rtc_pins_pkg::REC_HOLD_CYCLES,
	parameter int OSF_DELAY_CYCLES      = rtc_pins_pkg::OSF_DELAY_CYCLES,
	parameter int SERIAL_TIMEOUT_CYCLES = rtc_pins_pkg::SERIAL_TIMEOUT_CYCLES
) (
	input  wire logic       i_clk,
	input  wire logic       i_rst_b,
	input  wire logic       i_supply_below_threshold,
	input  wire logic       i_on_battery,
	input  wire logic       i_osc_clk,
	input  wire logic       i_rst_pin,
	output logic            o_rst_pin_out,
	output logic            o_rst_pin_oe,
	output logic            o_irq_or_wave_pin_out,
	output logic            o_irq_or_wave_pin_oe,
	output logic            o_clk_out,
	output logic            o_osc_enable,
	input  wire logic       i_ctl_wr,
	input  wire logic [7:0] i_ctl_addr,
	input  wire logic [7:0] i_ctl_wdata,
	output logic      [7:0] o_ctl_rdata,
	input  wire logic       i_clk_out_enable,
	input  wire logic       i_clk_out_battery_enable,
	output logic            o_osc_stop_flag,
	input  wire logic       i_osc_stop_clear,
	input  wire logic       i_alarm1_match,
	input  wire logic       i_alarm2_match,
	input  wire logic [1:0] i_alarm_clear,
	output logic      [1:0] o_alarm_flags,
	input  wire logic       i_serial_busy,
	input  wire logic       i_serial_activity,
	output logic            o_serial_abort
);
	pin_sense_if sense ();

	pin_conditioner u_cond (
		.i_clk   (i_clk),
		.i_rst_b (i_rst_b),
		.i_raw   ({i_osc_clk, i_rst_pin, i_on_battery, i_supply_below_threshold}),
		.sense   (sense.conditioner)
	);

	logic supply_low;
	logic on_battery;
	logic rst_sense;
	logic osc_sense;

	assign supply_low = sense.level[rtc_pins_pkg::SENSE_SUPPLY];
	assign on_battery = sense.level[rtc_pins_pkg::SENSE_BATT];
	assign rst_sense  = sense.level[rtc_pins_pkg::SENSE_RST];
	assign osc_sense  = sense.level[rtc_pins_pkg::SENSE_OSC];

	function automatic logic [rtc_pins_pkg::WAVE_W-1:0] half_period(input logic [1:0] rate);
		case (rate)
			2'h0:    half_period = rtc_pins_pkg::HALF_RATE_0;
			2'h1:    half_period = rtc_pins_pkg::HALF_RATE_1;
			2'h2:    half_period = rtc_pins_pkg::HALF_RATE_2;
			default: half_period = rtc_pins_pkg::HALF_RATE_3;
		endcase
	endfunction : half_period

	// Control register decode, shared by the write strobe and the read path
	function automatic logic hits_ctl(input logic [7:0] addr);
		return addr == rtc_pins_pkg::CTL_ADDR;
	endfunction : hits_ctl

	////////////////////////////////////////////////////////////////
	// Reset pin sequencer
	rtc_pins_pkg::rst_state_t state;
	rtc_pins_pkg::rst_state_t next_state;
	logic [31:0]              timer;
	logic [31:0]              next_timer;
	logic                     rst_prev;
	logic [7:0]               ctl;
	logic                     osc_dis;
	logic                     btn_fall;

	assign osc_dis  = ctl[rtc_pins_pkg::CTL_OSC_DIS];
	assign btn_fall = rst_prev & ~rst_sense;

	always_comb begin
		next_state = state;
		next_timer = timer + 32'h1;
		case (state)
			rtc_pins_pkg::POWER_FAIL: begin
				next_timer = 32'h0;
				if (!supply_low) begin
					next_state = osc_dis ? rtc_pins_pkg::IDLE : rtc_pins_pkg::RECOVER;
				end
			end
			rtc_pins_pkg::RECOVER: begin
				if (timer == 32'(REC_HOLD_CYCLES - 1)) begin
					next_state = rtc_pins_pkg::IDLE;
				end
			end
			rtc_pins_pkg::IDLE: begin
				next_timer = 32'h0;
				if (btn_fall) begin
					next_state = rtc_pins_pkg::DEBOUNCE;
				end
			end
			rtc_pins_pkg::DEBOUNCE: begin
				if (timer == 32'(DEBOUNCE_CYCLES - 1)) begin
					next_state = rtc_pins_pkg::WAIT_RISE;
				end
			end
			rtc_pins_pkg::WAIT_RISE: begin
				// Pin is released here, so the button level is visible again
				next_timer = 32'h0;
				if (rst_sense) begin
					next_state = rtc_pins_pkg::RST_HOLD;
				end
			end
			rtc_pins_pkg::RST_HOLD: begin
				if (timer == 32'(RST_HOLD_CYCLES - 1)) begin
					next_state = rtc_pins_pkg::IDLE;
				end
			end
			default: begin
				next_state = rtc_pins_pkg::POWER_FAIL;
				next_timer = 32'h0;
			end
		endcase
		// Power fail overrides any button cycle in progress
		if (supply_low) begin
			next_state = rtc_pins_pkg::POWER_FAIL;
			next_timer = 32'h0;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state    <= rtc_pins_pkg::POWER_FAIL;
			timer    <= 32'h0;
			rst_prev <= 1'h1;
		end else begin
			state    <= next_state;
			timer    <= next_timer;
			rst_prev <= rst_sense;
		end
	end

	// Open drain: only ever pulls low
	assign o_rst_pin_out = 1'h0;
	assign o_rst_pin_oe  = (state != rtc_pins_pkg::IDLE) && (state != rtc_pins_pkg::WAIT_RISE);

	////////////////////////////////////////////////////////////////
	// Control register, alarms and pin outputs
	logic [7:0]                     next_ctl;
	logic [7:0]                     next_rdata;
	logic [1:0]                     next_alarm;
	logic                           irq_level;
	logic                           wave;
	logic                           next_wave;
	logic [rtc_pins_pkg::WAVE_W-1:0] wave_cnt;
	logic [rtc_pins_pkg::WAVE_W-1:0] next_wave_cnt;
	logic                           osc_prev;
	logic                           osc_rise;
	logic                           next_irq_oe;
	logic                           next_clk_out;
	logic                           next_osc_enable;
	logic                           wave_sel;

	assign wave_sel = ~ctl[rtc_pins_pkg::CTL_SELECT];
	assign osc_rise = osc_sense & ~osc_prev;
	assign irq_level = ctl[rtc_pins_pkg::CTL_SELECT] &
		((o_alarm_flags[0] & ctl[rtc_pins_pkg::CTL_A1_EN]) |
		 (o_alarm_flags[1] & ctl[rtc_pins_pkg::CTL_A2_EN]));

	always_comb begin
		next_ctl = ctl;
		if (i_ctl_wr && hits_ctl(i_ctl_addr)) begin
			next_ctl = i_ctl_wdata;
		end
		next_rdata = hits_ctl(i_ctl_addr) ? ctl : 8'h00;
		// A match in the clearing cycle keeps the flag set
		next_alarm = (o_alarm_flags & ~i_alarm_clear) | {i_alarm2_match, i_alarm1_match};
		next_wave     = wave;
		next_wave_cnt = wave_cnt;
		if (osc_rise) begin
			if (wave_cnt >= half_period({ctl[rtc_pins_pkg::CTL_RATE_HI], ctl[rtc_pins_pkg::CTL_RATE_LO]}) - 15'h1) begin
				next_wave_cnt = '0;
				next_wave     = ~wave;
			end else begin
				next_wave_cnt = wave_cnt + 15'h1;
			end
		end
		next_irq_oe     = wave_sel ? ~wave : irq_level;
		next_clk_out    = osc_sense & i_clk_out_enable & i_clk_out_battery_enable;
		next_osc_enable = ~(on_battery & osc_dis);
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ctl                  <= rtc_pins_pkg::CTL_RESET;
			o_ctl_rdata          <= 8'h00;
			o_alarm_flags        <= 2'h0;
			wave                 <= 1'h0;
			wave_cnt             <= '0;
			osc_prev             <= 1'h0;
			o_irq_or_wave_pin_oe <= 1'h0;
			o_clk_out            <= 1'h0;
			o_osc_enable         <= 1'h1;
		end else begin
			ctl                  <= next_ctl;
			o_ctl_rdata          <= next_rdata;
			o_alarm_flags        <= next_alarm;
			wave                 <= next_wave;
			wave_cnt             <= next_wave_cnt;
			osc_prev             <= osc_sense;
			o_irq_or_wave_pin_oe <= next_irq_oe;
			o_clk_out            <= next_clk_out;
			o_osc_enable         <= next_osc_enable;
		end
	end

	assign o_irq_or_wave_pin_out = 1'h0;

	////////////////////////////////////////////////////////////////
	// Oscillator stop detect and serial timeout
	logic [31:0] stop_cnt;
	logic [31:0] next_stop_cnt;
	logic        next_osf;
	logic        osc_change;
	logic [31:0] to_cnt;
	logic [31:0] next_to_cnt;
	logic        next_abort;
	logic        stop_done;

	assign osc_change = osc_sense ^ osc_prev;
	assign stop_done  = (stop_cnt == 32'(OSF_DELAY_CYCLES - 1));

	always_comb begin
		next_stop_cnt = osc_change ? 32'h0 : (stop_done ? stop_cnt : stop_cnt + 32'h1);
		next_osf      = (o_osc_stop_flag & ~i_osc_stop_clear) | (stop_done & ~osc_change);
		next_to_cnt   = 32'h0;
		next_abort    = 1'h0;
		if (i_serial_busy && !i_serial_activity) begin
			if (to_cnt == 32'(SERIAL_TIMEOUT_CYCLES - 1)) begin
				next_abort = 1'h1;
			end else begin
				next_to_cnt = to_cnt + 32'h1;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			stop_cnt        <= 32'h0;
			o_osc_stop_flag <= rtc_pins_pkg::OSF_RESET;
			to_cnt          <= 32'h0;
			o_serial_abort  <= 1'h0;
		end else begin
			stop_cnt        <= next_stop_cnt;
			o_osc_stop_flag <= next_osf;
			to_cnt          <= next_to_cnt;
			o_serial_abort  <= next_abort;
		end
	end

	////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	a_pf_pin_low: assert property (supply_low |=> o_rst_pin_oe)
		else $error("reset pin not low during power fail");
	a_rec_hold_len: assert property ($past(state) == rtc_pins_pkg::RECOVER && state == rtc_pins_pkg::IDLE
		|-> $past(timer) == 32'(REC_HOLD_CYCLES - 1))
		else $error("recovery hold wrong length");
	a_rec_bypass: assert property (state == rtc_pins_pkg::POWER_FAIL && !supply_low && osc_dis
		|=> !o_rst_pin_oe)
		else $error("recovery hold not bypassed");
	a_button_start: assert property (state == rtc_pins_pkg::IDLE && btn_fall && !supply_low
		|=> o_rst_pin_oe && state == rtc_pins_pkg::DEBOUNCE)
		else $error("button edge did not start reset");
	a_debounce_len: assert property ($past(state) == rtc_pins_pkg::DEBOUNCE && state == rtc_pins_pkg::WAIT_RISE
		|-> $past(timer) == 32'(DEBOUNCE_CYCLES - 1))
		else $error("debounce wrong length");
	a_osf_delay: assert property ($rose(o_osc_stop_flag) |-> $past(stop_cnt) == 32'(OSF_DELAY_CYCLES - 1))
		else $error("stop flag set early");
	a_clk_gate: assert property (!(i_clk_out_enable && i_clk_out_battery_enable) |=> !o_clk_out)
		else $error("clock output not held low");
	a_wave_mode: assert property (wave_sel ##1 wave_sel |-> o_irq_or_wave_pin_oe == !$past(wave))
		else $error("wave pin does not follow wave");
	a_irq_mode: assert property (!wave_sel |=> o_irq_or_wave_pin_oe == $past(irq_level))
		else $error("interrupt pin wrong");
	a_serial_abort: assert property (o_serial_abort |-> $past(i_serial_busy)
		&& $past(to_cnt) == 32'(SERIAL_TIMEOUT_CYCLES - 1))
		else $error("serial abort at wrong time");
	a_osc_stop: assert property (on_battery && osc_dis |=> !o_osc_enable)
		else $error("oscillator not stopped on battery");
endmodule : rtc_output_pin_control

// *** dv/rst_button_model.sv ***
// Pushbutton on the pulled-up reset wire, as the host's reset input sees it
`timescale 1ns/1ps
module rst_button_model (
	input  wire logic i_press,
	input  wire logic i_dev_pull,
	output logic      o_wire
);
	// The pull-up only wins while neither the button nor the device pulls low
	assign o_wire = !(i_press || i_dev_pull);
endmodule : rst_button_model

// *** dv/tb_rtc_output_pin_control.sv ***
// Self-checking testbench of the reset, irq/wave and clock-out pin logic
`timescale 1ns/1ps
module tb_rtc_output_pin_control;
	localparam int DEB = 20;
	localparam int HOLD = 20;
	localparam int REC = 10;
	localparam int OSC_STOP_FLAG = 200;
	localparam int TMO = 30;
	typedef struct {logic [7:0] ctl; logic en; logic bb; logic clk_on; int half;} row_t;
	row_t rows [3] = '{'{8'h18, 1, 1, 1, 2}, '{8'h10, 1, 0, 0, 4}, '{8'h08, 0, 1, 0, 16}};
	logic       clk = 0, rst_b = 0, sup = 0, batt = 0, osc = 0, osc_run = 1, press = 0, wr = 0;
	logic       en = 0, bb = 0, osc_clr = 0, m1 = 0, m2 = 0, busy = 0, act = 0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d;
	logic [1:0] aclr = 2'h0, aflags, odiv = 2'h0;
	logic       pin, rst_oe, irq_oe, clk_out, osc_en, osc_stop_flag, abort, c, rst_out, irq_out;
	int         error_cnt = 0, total_checks = 0, n, tg;

	always #12.5 clk = ~clk;
	// Oscillator period is 8 core cycles so every wave rate but the slowest fits the run
	always @(posedge clk) if (osc_run) begin
		odiv <= odiv + 2'h1;
		if (odiv == 2'h3) osc <= ~osc;
	end

	rtc_output_pin_control #(.DEBOUNCE_CYCLES(DEB), .RST_HOLD_CYCLES(HOLD), .REC_HOLD_CYCLES(REC),
		.OSF_DELAY_CYCLES(OSC_STOP_FLAG), .SERIAL_TIMEOUT_CYCLES(TMO)) rtc_output_pin_control_i (
		.i_clk(clk), .i_rst_b(rst_b), .i_supply_below_threshold(sup), .i_on_battery(batt),
		.i_osc_clk(osc), .i_rst_pin(pin), .o_rst_pin_out(rst_out), .o_rst_pin_oe(rst_oe),
		.o_irq_or_wave_pin_out(irq_out), .o_irq_or_wave_pin_oe(irq_oe), .o_clk_out(clk_out),
		.o_osc_enable(osc_en), .i_ctl_wr(wr), .i_ctl_addr(addr), .i_ctl_wdata(wdata), .o_ctl_rdata(rdata),
		.i_clk_out_enable(en), .i_clk_out_battery_enable(bb), .o_osc_stop_flag(osc_stop_flag),
		.i_osc_stop_clear(osc_clr), .i_alarm1_match(m1), .i_alarm2_match(m2), .i_alarm_clear(aclr),
		.o_alarm_flags(aflags), .i_serial_busy(busy), .i_serial_activity(act), .o_serial_abort(abort));

	rst_button_model rst_button_model_i (.i_press(press), .i_dev_pull(rst_oe), .o_wire(pin));

	////////////////////////////////////////////////////////////////////////////////
	task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task wr_reg(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		wr <= 1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 0;
	endtask : wr_reg

	task rd_reg(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		@(posedge clk);
		#1;
		v = rdata;
	endtask : rd_reg

	function logic sig(input int s);
		return s ? irq_oe : rst_oe;
	endfunction : sig

	// Counts the cycles for which the chosen pin enable keeps its present value
	task span(input int s, output int k);
		logic v;
		v = sig(s);
		k = 0;
		while (sig(s) === v && k < 20000) begin
			@(posedge clk);
			#1;
			k++;
		end
	endtask : span

	task tally_and_finish;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish

	initial begin
		#(25 * 50000);
		error_cnt++;
		tally_and_finish();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge clk);
		#1;
		chk("rst_oe in reset", 1, rst_oe);
		chk("open drain data", 2'h0, {rst_out, irq_out});
		chk("stop flag in reset", 1, osc_stop_flag);
		chk("clk_out in reset", 0, clk_out);
		chk("irq_oe in reset", 0, irq_oe);
		@(posedge clk) rst_b <= 1;
		#1;
		span(0, n);
		chk("recovery hold", 1, n >= REC && n <= REC + 6);
		rd_reg(8'h0e, d);
		chk("control reset", 8'h04, d);
		wr_reg(8'h0f, 8'hff);
		rd_reg(8'h0f, d);
		chk("unmapped read", 8'h00, d);
		rd_reg(8'h0e, d);
		chk("control untouched", 8'h04, d);
		$display("reset and register test done");
		for (int i = 0; i < 3; i++) begin
			wr_reg(8'h0e, rows[i].ctl);
			en <= rows[i].en;
			bb <= rows[i].bb;
			tg = 0;
			@(posedge clk);
			#1;
			c = clk_out;
			repeat (40) begin
				@(posedge clk);
				#1;
				if (clk_out !== c) tg++;
				c = clk_out;
			end
			chk("clk_out running", rows[i].clk_on, tg != 0);
			span(1, n);
			span(1, n);
			chk("wave half period", rows[i].half * 8, n);
			$display("row %0d done", i);
		end
		wr_reg(8'h0e, 8'h05);
		@(posedge clk) m2 <= 1;
		@(posedge clk) m2 <= 0;
		repeat (3) @(posedge clk);
		#1;
		chk("alarm flags", 2'h2, aflags);
		chk("irq disabled alarm", 0, irq_oe);
		@(posedge clk) m1 <= 1;
		@(posedge clk) m1 <= 0;
		repeat (3) @(posedge clk);
		#1;
		chk("irq enabled alarm", 1, irq_oe);
		@(posedge clk) aclr <= 2'h3;
		@(posedge clk) aclr <= 2'h0;
		repeat (3) @(posedge clk);
		#1;
		chk("irq cleared", 0, irq_oe);
		$display("interrupt test done");
		@(posedge clk) press <= 1;
		#1;
		span(0, n);
		span(0, n);
		chk("debounce low", 1, n >= DEB && n <= DEB + 1);
		repeat (10) @(posedge clk);
		#1;
		chk("wait for release", 0, rst_oe);
		@(posedge clk) press <= 0;
		#1;
		span(0, n);
		chk("release seen", 1, n <= 6);
		span(0, n);
		chk("reset hold", 1, n >= HOLD && n <= HOLD + 1);
		$display("pushbutton test done");
		@(posedge clk) sup <= 1;
		repeat (6) @(posedge clk);
		#1;
		chk("power fail", 1, rst_oe);
		wr_reg(8'h0e, 8'h80);
		sup <= 0;
		#1;
		span(0, n);
		chk("hold bypassed", 1, n < REC);
		@(posedge clk) batt <= 1;
		repeat (6) @(posedge clk);
		#1;
		chk("osc stopped", 0, osc_en);
		wr_reg(8'h0e, 8'h04);
		batt <= 0;
		$display("power test done");
		@(posedge clk) osc_clr <= 1;
		@(posedge clk) osc_clr <= 0;
		repeat (3) @(posedge clk);
		#1;
		chk("stop flag cleared", 0, osc_stop_flag);
		chk("osc restarted", 1, osc_en);
		@(posedge clk) osc_run <= 0;
		#1;
		n = 0;
		while (osc_stop_flag !== 1 && n < 1000) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("stop detect delay", 1, n >= OSC_STOP_FLAG - 4 && n <= OSC_STOP_FLAG + 8);
		@(posedge clk) osc_run <= 1;
		$display("stop flag test done");
		@(posedge clk) busy <= 1;
		for (int i = 0; i < 100; i++) begin
			// Last activity pulse falls on the final pass, so the stall is timed from it
			@(posedge clk) act <= (i % 10 == 9);
			#1;
			chk("no abort while clocked", 0, abort);
		end
		@(posedge clk) act <= 0;
		#1;
		n = 0;
		while (abort !== 1 && n < 200) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("stall abort", 1, n >= TMO && n <= TMO + 4);
		$display("serial timeout test done");
		tally_and_finish();
	end
endmodule : tb_rtc_output_pin_control
